// ==== hbridge_reset_fault_control.sv ====
// reset timing, fault supervision and bridge output control of an h-bridge stage
// assumes all inputs asynchronous to CLOCK; pins resolved outside from level and enable
`timescale 1ns/1ps
`default_nettype none

module hbridge_reset_fault_control
  import hbridge_pkg::*;
#(
  parameter int RESET_CYCLES_P = hbridge_pkg::RESET_CYCLES,
  parameter int PWM_TIMEOUT_P  = hbridge_pkg::PWM_TIMEOUT_CYCLES
) (
  // clock and core reset
  input  wire logic                    CLOCK,
  input  wire logic                    ARST_N,
  // control pins
  input  wire logic                    RESET_N,
  input  wire logic                    POWER_DOWN_N,
  input  wire hbridge_pkg::pwm_in_type PWM_IN,
  // analog sense comparators
  input  wire logic                    OVERCURRENT,
  input  wire logic                    TEMP_ABOVE_WARN,
  input  wire logic                    TEMP_ABOVE_SHUT,
  input  wire logic                    GATE_REG_OK_A,
  input  wire logic                    GATE_REG_OK_B,
  // bridge outputs
  output var  hbridge_pkg::pin_type    BRIDGE_OUT_POS,
  output var  hbridge_pkg::pin_type    BRIDGE_OUT_NEG,
  // open-drain status flags
  output var  hbridge_pkg::pin_type    SHUTDOWN_FLAG,
  output var  hbridge_pkg::pin_type    FAULT_CODE_BIT1,
  output var  hbridge_pkg::pin_type    FAULT_CODE_BIT0
);
  import hbridge_pkg::*;

  localparam int RW = $clog2(RESET_CYCLES_P + 1);
  localparam int AW = $clog2(PWM_TIMEOUT_P + 1);
  localparam int FW = $clog2(ILLEGAL_FILT_CYCLES + 1);

  if (RESET_CYCLES_P < 1 || PWM_TIMEOUT_P < 2) begin : g_bad_param
    $error("counts too small");
  end

  // two-flop synchroniser
  logic [SYNC_WIDTH-1:0] sync1_r;
  logic [SYNC_WIDTH-1:0] sync2_r;
  wire  [SYNC_WIDTH-1:0] pins_in = {PWM_IN, RESET_N, POWER_DOWN_N, OVERCURRENT,
                                    TEMP_ABOVE_WARN, TEMP_ABOVE_SHUT,
                                    GATE_REG_OK_A, GATE_REG_OK_B};

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
    end
  end

  wire [3:0] pwm_s   = sync2_r[10:7];
  wire       rst_s   = sync2_r[6];
  wire       pwr_s   = sync2_r[5];
  wire       oc_s    = sync2_r[4];
  wire       warn_s  = sync2_r[3];
  wire       shut_s  = sync2_r[2];
  wire       uv      = !(sync2_r[1] && sync2_r[0]);

  // reset operation timer
  logic          rst_d_r;
  logic [RW-1:0] rst_cnt_r;
  logic [RW-1:0] rst_cnt_nxt;
  wire           rst_fall = !rst_s && rst_d_r;
  wire           in_reset = !rst_s || (rst_cnt_r != '0);
  assign rst_cnt_nxt = rst_fall ? RW'(RESET_CYCLES_P) :
                       (rst_cnt_r != '0) ? rst_cnt_r - RW'(1) : '0;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_d_r   <= 1'b0;
      rst_cnt_r <= RW'(RESET_CYCLES_P);
    end else begin
      rst_d_r   <= rst_s;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // pwm activity detectors, one per input
  logic [3:0] pwm_d_r;
  logic [3:0] stale;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pwm_d_r <= '0;
    end else begin
      pwm_d_r <= pwm_s;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_act
    logic [AW-1:0] cnt_r;
    logic [AW-1:0] cnt_nxt;
    assign cnt_nxt  = (in_reset || (pwm_s[i] != pwm_d_r[i])) ? '0 :
                      (cnt_r == AW'(PWM_TIMEOUT_P)) ? cnt_r : cnt_r + AW'(1);
    assign stale[i] = (cnt_r == AW'(PWM_TIMEOUT_P));
    always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  wire pwm_lost = |stale;

  // illegal pair filter, ignores edge skew between complementary inputs
  logic [FW-1:0] ill_cnt_r;
  logic [FW-1:0] ill_cnt_nxt;
  wire           pair_bad  = (pwm_s[3] == pwm_s[2]) || (pwm_s[1] == pwm_s[0]);
  wire           ill_full  = (ill_cnt_r == FW'(ILLEGAL_FILT_CYCLES));
  wire           illegal_on = !in_reset && (ill_full || pwm_lost);
  assign ill_cnt_nxt = (in_reset || !pair_bad) ? '0 :
                       ill_full ? ill_cnt_r : ill_cnt_r + FW'(1);

  // short-circuit latch and overtemperature hysteresis
  logic sc_r;
  logic ot_r;
  wire  sc_nxt = !rst_s ? 1'b0 : (sc_r || (oc_s && pwr_s));
  wire  ot_nxt = shut_s ? 1'b1 : (warn_s ? ot_r : 1'b0);

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ill_cnt_r <= '0;
      sc_r      <= 1'b0;
      ot_r      <= 1'b0;
    end else begin
      ill_cnt_r <= ill_cnt_nxt;
      sc_r      <= sc_nxt;
      ot_r      <= ot_nxt;
    end
  end

  // status code with fixed priority
  wire       fault_free = !sc_r && !illegal_on && !ot_r && !uv;
  wire [2:0] code = sc_r       ? CODE_SHORT   :
                    illegal_on ? CODE_ILLEGAL :
                    ot_r       ? CODE_OVERTMP :
                    uv         ? CODE_LOWREG  :
                    warn_s     ? CODE_WARN    : CODE_NORMAL;

  // bridge drive
  wire hold_low = in_reset || !fault_free;
  wire drv_oe   = pwr_s && !sc_r;
  wire pos_lvl  = !hold_low && pwm_s[3];
  wire neg_lvl  = !hold_low && pwm_s[1];

  pin_type pos_r;
  pin_type neg_r;
  pin_type sd_r;
  pin_type b1_r;
  pin_type b0_r;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pos_r <= '0;
      neg_r <= '0;
      sd_r  <= '0;
      b1_r  <= '0;
      b0_r  <= '0;
    end else begin
      pos_r <= '{lvl: pos_lvl && drv_oe, oe: drv_oe};
      neg_r <= '{lvl: neg_lvl && drv_oe, oe: drv_oe};
      sd_r  <= '{lvl: 1'b0, oe: pwr_s && !code[2]};
      b1_r  <= '{lvl: 1'b0, oe: pwr_s && !code[1]};
      b0_r  <= '{lvl: 1'b0, oe: pwr_s && !code[0]};
    end
  end

  assign BRIDGE_OUT_POS  = pos_r;
  assign BRIDGE_OUT_NEG  = neg_r;
  assign SHUTDOWN_FLAG   = sd_r;
  assign FAULT_CODE_BIT1 = b1_r;
  assign FAULT_CODE_BIT0 = b0_r;

  wire [2:0] flags_seen = {!sd_r.oe, !b1_r.oe, !b0_r.oe};

  chk_reset_drives_low: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (in_reset && pwr_s && !sc_r) |=> (pos_r.oe && !pos_r.lvl && neg_r.oe && !neg_r.lvl))
    else $error("reset did not drive outputs low");

  chk_reset_clears_latch: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !rst_s |=> !sc_r)
    else $error("short latch survived reset");

  chk_lowreg_code: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (uv && pwr_s && !sc_r && !illegal_on && !ot_r) |=>
      (flags_seen == CODE_LOWREG && !pos_r.lvl && !neg_r.lvl))
    else $error("low regulator not reported");

  chk_normal_follows: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (fault_free && !in_reset && pwr_s) |=>
      (pos_r.oe && pos_r.lvl == $past(pwm_s[3]) && neg_r.lvl == $past(pwm_s[1])))
    else $error("bridge not following pwm");

  chk_warn_code: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (fault_free && warn_s && pwr_s) |=> flags_seen == CODE_WARN)
    else $error("warning code missing");

  chk_ot_set: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    shut_s |=> ot_r ##1 (!pwr_s || sc_r || illegal_on || !pos_r.lvl))
    else $error("overtemperature not taken");

  chk_ot_hysteresis: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (ot_r && warn_s) |=> ot_r)
    else $error("overtemperature released above warning");

  chk_illegal_code: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (illegal_on && !sc_r && pwr_s) |=> flags_seen == CODE_ILLEGAL)
    else $error("illegal pwm not reported");

  chk_short_hiz: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (sc_r && pwr_s) |=> (!pos_r.oe && !neg_r.oe && flags_seen == CODE_SHORT))
    else $error("short latch not floating outputs");

  chk_pd_release: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !pwr_s |=> (!pos_r.oe && !neg_r.oe && !sd_r.oe && !b1_r.oe && !b0_r.oe))
    else $error("power down not releasing pins");

  chk_pwm_timeout: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(pwm_lost) |->
      (!$past(in_reset) && ((($past(pwm_s) ^ $past(pwm_d_r)) & stale) == 4'h0)))
    else $error("loss of pwm without stall");

endmodule // hbridge_reset_fault_control

`default_nettype wire

// ==== hbridge_pkg.sv ====
// shared constants and carrier types for the h-bridge reset and fault supervisor
// assumes a single 200 MHz core clock
package hbridge_pkg;

  // timing
  localparam int CLK_PERIOD_PS      = 5000;
  localparam int RESET_TIME_MS      = 1;
  localparam int RESET_CYCLES       = (RESET_TIME_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int PWM_PERIOD_NS      = 2604;
  localparam int PWM_TIMEOUT_PERIODS = 8;
  localparam int PWM_TIMEOUT_CYCLES =
    (PWM_TIMEOUT_PERIODS * PWM_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ILLEGAL_FILT_CYCLES = 4;
  localparam int SYNC_WIDTH          = 11;

  // flag codes: shutdown, bit1, bit0
  localparam logic [2:0] CODE_ILLEGAL = 3'h0;
  localparam logic [2:0] CODE_SHORT   = 3'h1;
  localparam logic [2:0] CODE_OVERTMP = 3'h2;
  localparam logic [2:0] CODE_LOWREG  = 3'h3;
  localparam logic [2:0] CODE_WARN    = 3'h6;
  localparam logic [2:0] CODE_NORMAL  = 3'h7;

  typedef struct packed {
    logic pwm_side_a_pos;
    logic pwm_side_a_neg;
    logic pwm_side_b_pos;
    logic pwm_side_b_neg;
  } pwm_in_type;

  // three-state or open-drain pin: level and enable
  typedef struct packed {
    logic lvl;
    logic oe;
  } pin_type;

endpackage

// ==== pwm_source.sv ====
// pwm modulator model: complementary pairs, with stall and illegal modes
// assumes mode changes just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module pwm_source (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  // 0 run, 1 stall, 2 illegal pair
  input  wire logic [1:0]              mode,
  // pwm pins
  output var  hbridge_pkg::pwm_in_type pwm
);
  import hbridge_pkg::*;
  logic [2:0] cnt_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 3'h0;
      pwm   <= '0;
    end else if (mode == 2'h2) begin
      pwm <= 4'hF;
    end else if (mode == 2'h0) begin
      cnt_r <= cnt_r + 3'h1;
      pwm   <= {cnt_r[2], ~cnt_r[2], ~cnt_r[2], cnt_r[2]};
    end
  end
endmodule // pwm_source
`default_nettype wire

// ==== hbridge_reset_fault_control_tb.sv ====
// self-checking bench for the h-bridge reset and fault supervisor
// assumes hbridge_pkg and pwm_source are compiled first
`timescale 1ns/1ps
`default_nettype none
module hbridge_reset_fault_control_tb;
  import hbridge_pkg::*;
  logic       clock = 1'b0, arst_n = 1'b0, reset_n = 1'b0, pwr_n = 1'b1, ovc = 1'b0;
  logic       warn = 1'b0, shut = 1'b0, reg_a = 1'b1, reg_b = 1'b1;
  logic [1:0] mode = 2'h0;
  pwm_in_type pwm;
  pin_type    out_pos, out_neg, sd, b1, b0;
  logic [5:0] lvl_pipe = 6'h00;
  int         fail_count = 0, checks_done = 0, cycles = 0;

  always #2.5 clock = ~clock;

  // pwm levels seen at falling edges; outputs trail them by three edges
  always @(negedge clock) begin
    lvl_pipe <= {lvl_pipe[3:0], pwm.pwm_side_a_pos, pwm.pwm_side_b_pos};
  end

  pwm_source pwm_source_inst (.clock(clock), .arst_n(arst_n), .mode(mode), .pwm(pwm));
  hbridge_reset_fault_control #(.RESET_CYCLES_P(20), .PWM_TIMEOUT_P(16))
    hbridge_reset_fault_control_inst (.CLOCK(clock), .ARST_N(arst_n), .RESET_N(reset_n),
    .POWER_DOWN_N(pwr_n), .PWM_IN(pwm), .OVERCURRENT(ovc), .TEMP_ABOVE_WARN(warn),
    .TEMP_ABOVE_SHUT(shut), .GATE_REG_OK_A(reg_a), .GATE_REG_OK_B(reg_b),
    .BRIDGE_OUT_POS(out_pos), .BRIDGE_OUT_NEG(out_neg), .SHUTDOWN_FLAG(sd),
    .FAULT_CODE_BIT1(b1), .FAULT_CODE_BIT0(b0));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic compare(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // settle, then check flag code and the cared-for output pin bits
  task automatic expect_state(input logic [2:0] code, input logic [3:0] pins,
                              input logic [3:0] care);
    repeat (40) @(posedge clock);
    @(negedge clock);
    compare("fault code", {1'b0, code}, {1'b0, ~sd.oe, ~b1.oe, ~b0.oe});
    compare("flag levels", 4'h0, {1'b0, sd.lvl, b1.lvl, b0.lvl});
    compare("bridge pins", pins,
            {out_pos.lvl, out_pos.oe, out_neg.lvl, out_neg.oe} & care);
    if (pins == 4'h5 && care == 4'h5) begin
      repeat (8) begin
        @(negedge clock);
        compare("bridge levels", {2'h0, lvl_pipe[5:4]}, {2'h0, out_pos.lvl, out_neg.lvl});
      end
    end
    @(posedge clock);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    mode   <= 2'h2;
    expect_state(3'h7, 4'h5, 4'hF);
    mode    <= 2'h0;
    reset_n <= 1'b1;
    expect_state(3'h7, 4'h5, 4'h5);
    warn <= 1'b1;
    expect_state(3'h6, 4'h5, 4'h5);
    shut <= 1'b1;
    expect_state(3'h2, 4'h5, 4'hF);
    shut <= 1'b0;
    expect_state(3'h2, 4'h5, 4'hF);
    warn <= 1'b0;
    expect_state(3'h7, 4'h5, 4'h5);
    reg_a <= 1'b0;
    expect_state(3'h3, 4'h5, 4'hF);
    reg_a <= 1'b1;
    reg_b <= 1'b0;
    expect_state(3'h3, 4'h5, 4'hF);
    reg_b <= 1'b1;
    expect_state(3'h7, 4'h5, 4'h5);
    for (int m = 1; m < 3; m++) begin
      mode <= m[1:0];
      expect_state(3'h0, 4'h5, 4'hF);
      mode <= 2'h0;
      expect_state(3'h7, 4'h5, 4'h5);
    end
    mode  <= 2'h2;
    shut  <= 1'b1;
    warn  <= 1'b1;
    reg_a <= 1'b0;
    expect_state(3'h0, 4'h5, 4'hF);
    mode <= 2'h0;
    expect_state(3'h2, 4'h5, 4'hF);
    ovc <= 1'b1;
    expect_state(3'h1, 4'h0, 4'h5);
    ovc   <= 1'b0;
    shut  <= 1'b0;
    warn  <= 1'b0;
    reg_a <= 1'b1;
    expect_state(3'h1, 4'h0, 4'h5);
    reset_n <= 1'b0;
    expect_state(3'h7, 4'h5, 4'hF);
    reset_n <= 1'b1;
    expect_state(3'h7, 4'h5, 4'h5);
    ovc     <= 1'b1;
    pwr_n   <= 1'b0;
    reset_n <= 1'b0;
    expect_state(3'h7, 4'h0, 4'h5);
    tally_and_finish();
  end
endmodule // hbridge_reset_fault_control_tb
`default_nettype wire
